/* File: rtl/sgmii_mgmt_consts.svh */
// Constants for the SGMII management status register bank
`ifndef SGMII_MGMT_CONSTS_SVH
`define SGMII_MGMT_CONSTS_SVH

// Register addresses on the management bus
`define ADDR_W             5
`define ADDR_STATUS        5'h01
`define ADDR_ID_HIGH       5'h02
`define ADDR_ID_LOW        5'h03
`define ADDR_EXT_STATUS    5'h0F
`define ADDR_GEN_CTRL      5'h12

// Status register bit positions
`define ST_AN_COMPLETE     5
`define ST_REMOTE_FAULT    4
`define ST_LINK            2

// Status constant bits: ext status, unidir, preamble suppr., AN ability
`define STATUS_CONST       16'h01C8
// Extended status: only 1000 Mb/s X full duplex
`define EXT_STATUS_VAL     16'h8000
// Generic control: disparity enable bit and its reset value
`define GEN_DISP_BIT       0
`define GEN_DISP_RESET     1'h0

// Link timer, in ns, and clock period, in ns
`define LINK_TIMER_NS      1600000
`define CLK_PERIOD_NS      10
`define LOSS_CNT_W         18

`endif

/* File: rtl/sgmii_mgmt_pkg.sv */
// Types shared by the SGMII management status register bank
`include "sgmii_mgmt_consts.svh"

package sgmii_mgmt_pkg;

   // One register access from the management frame engine
   typedef struct packed {
      logic                  rd;     // Read strobe, one cycle
      logic                  wr;     // Write strobe, one cycle
      logic [`ADDR_W-1:0]    addr;   // Register address
      logic [15:0]           wdata;  // Write data
   } mgmt_req_t;

   // Read answer back to the frame engine
   typedef struct packed {
      logic                  valid;  // One-cycle pulse
      logic [15:0]           data;   // Register contents
   } mgmt_rsp_t;

   typedef logic [`LOSS_CNT_W-1:0] loss_cnt_t;

   // Whole state of the register bank
   typedef struct packed {
      logic                  sync_ok;    // Filtered synchronisation
      loss_cnt_t             loss_cnt;   // Cycles without sync
      logic                  an_cmpl;    // Auto-negotiation done
      logic                  rfault;     // Sticky remote fault
      logic                  link_latch; // Latched-low link status
      logic                  disp_en;    // Disparity check enable
      mgmt_rsp_t             rsp;        // Registered read answer
   } state_t;

endpackage

/* File: rtl/sgmii_mgmt_status_regs.sv */
// SGMII channel management status, identifier and generic control regs
`timescale 1ns/1ps
`default_nettype none
`include "sgmii_mgmt_consts.svh"

module sgmii_mgmt_status_regs #(
   // Link timer in cycles; shorten in simulation
   parameter int          LINK_TIMER_CYC =
      (`LINK_TIMER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   // Identifier fields; values are arbitrary
   parameter logic [21:0] ID_ORG         = 22'h15A5A3,
   parameter logic [5:0]  ID_MODEL       = 6'h2A,
   parameter logic [3:0]  ID_REV         = 4'h3
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire sgmii_mgmt_pkg::mgmt_req_t req,
   input  wire logic                      link_sync,
   input  wire logic                      an_done,
   input  wire logic                      an_enable,
   input  wire logic                      remote_fault,
   output      sgmii_mgmt_pkg::mgmt_rsp_t rsp,
   output      logic                      disparity_en,
   output      logic                      link_valid
);
   import sgmii_mgmt_pkg::*;

   // Last count of the sync-loss timer
   localparam loss_cnt_t TIMER_LAST = loss_cnt_t'(LINK_TIMER_CYC - 1);

   state_t s_q;         // Registered state
   state_t s_d;         // Next state
   logic   link_good;   // Present link state
   logic   status_rd;   // Read of the status register this cycle
   logic   gen_wr;      // Write of the generic control register

   // Build the word returned for a register address
   function automatic logic [15:0] read_word(
      input logic [`ADDR_W-1:0] a,
      input state_t             s
   );
      logic [15:0] w;
      w = 16'h0000;                         // Unmapped reads give zero
      case (a)
         `ADDR_STATUS: begin
            w = `STATUS_CONST;
            w[`ST_AN_COMPLETE] = s.an_cmpl;
            w[`ST_REMOTE_FAULT] = s.rfault;
            w[`ST_LINK] = s.link_latch;
         end
         `ADDR_ID_HIGH: begin
            w = ID_ORG[21:6];
         end
         `ADDR_ID_LOW: begin
            w = {ID_ORG[5:0], ID_MODEL, ID_REV};
         end
         `ADDR_EXT_STATUS: begin
            w = `EXT_STATUS_VAL;
         end
         `ADDR_GEN_CTRL: begin
            w[`GEN_DISP_BIT] = s.disp_en;
         end
         default: begin
            w = 16'h0000;
         end
      endcase
      return w;
   endfunction

   // Decode of the accesses that have side effects. Only a read clears
   // the sticky bits; a write to status is ignored entirely.
   assign status_rd = req.rd && (req.addr == `ADDR_STATUS);
   assign gen_wr    = req.wr && (req.addr == `ADDR_GEN_CTRL);

   // The link counts as good only with filtered sync and, when AN is
   // enabled, a finished negotiation.
   assign link_good = s_q.sync_ok && (s_q.an_cmpl || !an_enable);

   // Next-state logic for the whole bank
   always_comb begin
      s_d = s_q;

      // Sync filter: rises at once, falls after a full link timer
      // without sync, so a brief glitch never drops the link.
      if (link_sync) begin
         s_d.sync_ok  = 1'b1;
         s_d.loss_cnt = '0;
      end else if (s_q.sync_ok) begin
         if (s_q.loss_cnt == TIMER_LAST) begin
            s_d.sync_ok  = 1'b0;
            s_d.loss_cnt = '0;
         end else begin
            s_d.loss_cnt = s_q.loss_cnt + loss_cnt_t'(1);
         end
      end else begin
         s_d.loss_cnt = '0;
      end

      // Negotiation done follows the state machine outside
      s_d.an_cmpl = an_done;

      // Remote fault: a new event wins over the clear of a read
      if (remote_fault) begin
         s_d.rfault = 1'b1;
      end else if (status_rd) begin
         s_d.rfault = 1'b0;
      end

      // Link latch: a read reloads the present state, otherwise any
      // drop pulls it to zero and it stays there until the next read.
      if (status_rd) begin
         s_d.link_latch = link_good;
      end else if (!link_good) begin
         s_d.link_latch = 1'b0;
      end

      // Only the disparity enable bit is writable
      if (gen_wr) begin
         s_d.disp_en = req.wdata[`GEN_DISP_BIT];
      end

      // Read answer is registered, one cycle after the strobe
      s_d.rsp.valid = req.rd;
      if (req.rd) begin
         s_d.rsp.data = read_word(req.addr, s_q);
      end
   end

   // State register, synchronous reset
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q.sync_ok    <= 1'b0;
         s_q.loss_cnt   <= '0;
         s_q.an_cmpl    <= 1'b0;
         s_q.rfault     <= 1'b0;
         s_q.link_latch <= 1'b0;
         s_q.disp_en    <= `GEN_DISP_RESET;
         s_q.rsp.valid  <= 1'b0;
         s_q.rsp.data   <= 16'h0000;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign rsp          = s_q.rsp;
   assign disparity_en = s_q.disp_en;
   assign link_valid   = s_q.link_latch;

   // Checks on the bank's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Ability bits never change whatever was written before
   a_status_zero_bits: assert property (
      status_rd |=> rsp.valid && (rsp.data[15:9] == 7'h00))
      else $error("status upper ability bits not zero");

   // Extended status, unidirectional and preambleless flags are fixed
   a_status_one_bits: assert property (
      status_rd |=> rsp.data[8] && rsp.data[7] && rsp.data[6])
      else $error("status bits 8..6 not one");

   // A status write shortly before a read must not reach bit 7
   a_unidir_write: assert property (
      (req.wr && req.addr == `ADDR_STATUS) ##[1:2] status_rd
      |=> rsp.data[7])
      else $error("write altered unidirectional ability");

   // Ability flag set, jabber and extended capability clear
   a_an_ability: assert property (
      status_rd |=> rsp.data[3] && (rsp.data[1:0] == 2'h0))
      else $error("status bits 3..0 constants wrong");

   // Read data carries the AN flag from two samples back: one edge
   // registers the input, the next registers the read answer.
   a_an_complete: assert property (
      status_rd |=> rsp.data[`ST_AN_COMPLETE] == $past(an_done, 2))
      else $error("AN complete bit not tracking");

   // Fault is caught and held until a read takes it
   a_fault_sticky: assert property (
      remote_fault ##1 (!status_rd && !remote_fault)[*2] |=> s_q.rfault)
      else $error("remote fault lost before read");

   a_fault_clear: assert property (
      status_rd && !remote_fault |=> !s_q.rfault)
      else $error("remote fault not cleared on read");

   // Writes, to any address, leave the fault flag alone
   a_fault_nowrite: assert property (
      req.wr && !req.rd && !remote_fault |=> s_q.rfault == $past(s_q.rfault))
      else $error("write changed remote fault");

   // Any cycle with a bad link pulls the latch low
   a_link_latch_low: assert property (
      !link_good |=> !s_q.link_latch)
      else $error("link latch not dropped");

   a_link_rise_cause: assert property (
      $rose(s_q.link_latch) |-> $past(status_rd) && $past(link_good))
      else $error("link rose without read of good link");

   // The filter may only fall once the full timer has run out
   a_sync_timer: assert property (
      $fell(s_q.sync_ok) |-> $past(s_q.loss_cnt) == TIMER_LAST
                             && !$past(link_sync))
      else $error("sync dropped before link timer");

   a_an_gates_link: assert property (
      an_enable && !s_q.an_cmpl |=> !s_q.link_latch)
      else $error("link up without AN while enabled");

   // Constant identifier, low word
   a_identifier: assert property (
      req.rd && req.addr == `ADDR_ID_LOW
      |=> rsp.data == {ID_ORG[5:0], ID_MODEL, ID_REV})
      else $error("identifier low word wrong");

   a_ext_status: assert property (
      req.rd && req.addr == `ADDR_EXT_STATUS
      |=> rsp.valid && rsp.data == `EXT_STATUS_VAL)
      else $error("extended status word wrong");

   a_disp_write: assert property (
      gen_wr ##1 (req.rd && req.addr == `ADDR_GEN_CTRL && !gen_wr)
      |=> rsp.data == {15'h0000, $past(req.wdata[`GEN_DISP_BIT], 2)})
      else $error("disparity enable read-back wrong");

   // Identifier high word is the top of the organisation code
   a_id_high_word: assert property (
      req.rd && req.addr == `ADDR_ID_HIGH
      |=> rsp.valid && rsp.data == ID_ORG[21:6])
      else $error("identifier high word wrong");

   // Every unsupported or reserved extended status bit stays clear
   a_ext_reserved: assert property (
      req.rd && req.addr == `ADDR_EXT_STATUS
      |=> rsp.data[14:0] == 15'h0000)
      else $error("extended status reserved bits set");

   // Only bit 0 of generic control can ever read back as one
   a_gen_reserved: assert property (
      req.rd && req.addr == `ADDR_GEN_CTRL
      |=> rsp.valid && rsp.data[15:1] == 15'h0000)
      else $error("generic control reserved bits set");

   // The enable output takes the written bit on the next edge and
   // holds it otherwise, so the receive checker never glitches.
   a_disp_out: assert property (
      gen_wr |=> disparity_en == $past(req.wdata[`GEN_DISP_BIT]))
      else $error("disparity enable did not take write");

   a_disp_hold: assert property (
      !gen_wr |=> disparity_en == $past(disparity_en))
      else $error("disparity enable changed without write");

   // Auto-negotiation complete is a one-cycle copy of the input
   a_an_follow: assert property (
      1'b1 |=> s_q.an_cmpl == $past(an_done))
      else $error("AN complete not following input");

   // A new fault event is held even if a read clears in that cycle
   a_fault_set: assert property (
      remote_fault |=> s_q.rfault)
      else $error("remote fault event missed");

   // A status read reloads the latch with the link state of that cycle
   a_link_reload: assert property (
      status_rd |=> s_q.link_latch == $past(link_good))
      else $error("link latch not reloaded on read");

   // Within the link timer a sync gap must not drop the filter
   a_sync_hold: assert property (
      s_q.sync_ok && !link_sync && s_q.loss_cnt != TIMER_LAST
      |=> s_q.sync_ok)
      else $error("sync dropped inside link timer");

   // Sync returns at once when the input is present again
   a_sync_rise: assert property (
      link_sync |=> s_q.sync_ok && s_q.loss_cnt == '0)
      else $error("sync filter did not follow input");

endmodule
`default_nettype wire

/* File: verification/mgmt_host_model.sv */
// Station management model that issues single register accesses
`timescale 1ns/1ps
`default_nettype none
`include "sgmii_mgmt_consts.svh"

module mgmt_host_model
   import sgmii_mgmt_pkg::*;
(
   input  wire logic      clk,
   output var  mgmt_req_t req,
   input  wire mgmt_rsp_t rsp
);
   // Bus idles with both strobes low
   initial req = '0;

   // One access: strobe for one edge, answer sampled one cycle later.
   // Idle address and data are inverted so stale values never help.
   task automatic xfer(input  logic               w,
                       input  logic [`ADDR_W-1:0] a,
                       input  logic [15:0]        d,
                       output logic [15:0]        q);
      @(posedge clk);
      req <= '{rd: !w, wr: w, addr: a, wdata: d};
      @(posedge clk);
      req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      #1;
      // Missing answer shows as unknown so the compare fails
      q = rsp.valid ? rsp.data : 16'hXXXX;
   endtask
endmodule
`default_nettype wire

/* File: verification/sgmii_mgmt_status_regs_bench.sv */
// Self-checking bench for the SGMII management status register bank
`timescale 1ns/1ps
`default_nettype none
`include "sgmii_mgmt_consts.svh"

module sgmii_mgmt_status_regs_bench;
   import sgmii_mgmt_pkg::*;
   localparam int          LT    = 8;        // Short link timer
   localparam logic [21:0] ORG   = 22'h2C3D1E; // Arbitrary value
   localparam logic [5:0]  MODEL = 6'h15;    // Arbitrary value
   localparam logic [3:0]  REV   = 4'h9;     // Arbitrary value
   localparam logic [15:0] ST    = `STATUS_CONST;

   logic      clk, rst, link_sync, an_done, an_enable, remote_fault;
   mgmt_req_t req;
   mgmt_rsp_t rsp;
   logic      disparity_en, link_valid;
   int        n_errors = 0;
   int        checks_done = 0;
   int        cycles = 0;

   sgmii_mgmt_status_regs #(.LINK_TIMER_CYC(LT), .ID_ORG(ORG),
      .ID_MODEL(MODEL), .ID_REV(REV)) sgmii_mgmt_status_regs_inst (
      .clk(clk), .rst(rst), .req(req), .link_sync(link_sync),
      .an_done(an_done), .an_enable(an_enable),
      .remote_fault(remote_fault), .rsp(rsp),
      .disparity_en(disparity_en), .link_valid(link_valid));

   mgmt_host_model mgmt_host_model_inst (
      .clk(clk), .req(req), .rsp(rsp));

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, far beyond the hundred or so cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         wrap_up;
      end
   end

   task automatic wrap_up;
      if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Read a register and compare with the expected word
   task automatic rd_chk(input string nm, input logic [4:0] a,
                         input logic [15:0] e);
      logic [15:0] d;
      mgmt_host_model_inst.xfer(1'b0, a, 16'h0000, d);
      chk(nm, e, d);
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] q;
      mgmt_host_model_inst.xfer(1'b1, a, d, q);
   endtask

   // Wait a few edges so level inputs settle through the filters
   task automatic settle;
      repeat (3) @(posedge clk);
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      link_sync = 1'b0;
      an_done = 1'b0;
      an_enable = 1'b1;
      remote_fault = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1 chk("disp_rst", 16'h0000, {15'h0, disparity_en});
      rd_chk("status_rst", `ADDR_STATUS, ST);
      rd_chk("id_high", `ADDR_ID_HIGH, ORG[21:6]);
      rd_chk("id_low", `ADDR_ID_LOW, {ORG[5:0], MODEL, REV});
      rd_chk("ext", `ADDR_EXT_STATUS, `EXT_STATUS_VAL);
      rd_chk("gen_rst", `ADDR_GEN_CTRL, 16'h0000);
      rd_chk("unmapped", 5'h07, 16'h0000);
      // Reserved control bits must not stick
      wr(`ADDR_GEN_CTRL, 16'hFFFF);
      chk("disp_on", 16'h0001, {15'h0, disparity_en});
      rd_chk("gen_on", `ADDR_GEN_CTRL, 16'h0001);
      wr(`ADDR_GEN_CTRL, 16'hFFFE);
      rd_chk("gen_off", `ADDR_GEN_CTRL, 16'h0000);
      // Fault event, then writes that must neither clear nor change
      @(posedge clk) remote_fault <= 1'b1;
      @(posedge clk) remote_fault <= 1'b0;
      wr(`ADDR_STATUS, 16'h0000);
      wr(`ADDR_ID_HIGH, 16'hFFFF);
      wr(`ADDR_EXT_STATUS, 16'h7FFF);
      rd_chk("id_high_wr", `ADDR_ID_HIGH, ORG[21:6]);
      rd_chk("ext_wr", `ADDR_EXT_STATUS, `EXT_STATUS_VAL);
      wr(`ADDR_STATUS, 16'hFF7F);
      rd_chk("fault_set", `ADDR_STATUS, ST | 16'h0010);
      rd_chk("fault_clr", `ADDR_STATUS, ST);
      // Link comes up; first read still shows the old low latch
      @(posedge clk) link_sync <= 1'b1;
      an_done <= 1'b1;
      settle;
      rd_chk("link_old", `ADDR_STATUS, ST | 16'h0020);
      rd_chk("link_up", `ADDR_STATUS, ST | 16'h0024);
      // Sync gap shorter than the link timer is ridden out
      @(posedge clk) link_sync <= 1'b0;
      repeat (LT - 2) @(posedge clk);
      link_sync <= 1'b1;
      settle;
      #1 chk("short_loss", 16'h0001, {15'h0, link_valid});
      rd_chk("short_rd", `ADDR_STATUS, ST | 16'h0024);
      // Gap longer than the link timer drops the latch
      @(posedge clk) link_sync <= 1'b0;
      repeat (LT + 4) @(posedge clk);
      #1 chk("long_loss", 16'h0000, {15'h0, link_valid});
      @(posedge clk) link_sync <= 1'b1;
      settle;
      rd_chk("relink_old", `ADDR_STATUS, ST | 16'h0020);
      rd_chk("relink", `ADDR_STATUS, ST | 16'h0024);
      // Negotiation enabled but not done: no valid link
      @(posedge clk) an_done <= 1'b0;
      settle;
      rd_chk("an_miss_old", `ADDR_STATUS, ST);
      rd_chk("an_miss", `ADDR_STATUS, ST);
      // Negotiation disabled: sync alone makes the link
      @(posedge clk) an_enable <= 1'b0;
      settle;
      rd_chk("an_off_old", `ADDR_STATUS, ST);
      rd_chk("an_off", `ADDR_STATUS, ST | 16'h0004);
      wrap_up;
   end
endmodule
`default_nettype wire
